// file: rtl/prot_map.svh
// Timing counts for the channel protection state machines
`ifndef PROT_MAP_SVH
`define PROT_MAP_SVH

// System clock period in ns (250 MHz)
`define CPF_CLK_NS 4
// Accumulated on-time before leaving inrush, in ns
`define CPF_INRUSH_ON_TIME_NS 10000
// Off-time before a channel re-arms into inrush, in ns
`define CPF_REARM_TIME_NS 10000
// Least times round up to whole cycles
`define CPF_INRUSH_ON_CYC ((`CPF_INRUSH_ON_TIME_NS + `CPF_CLK_NS - 1) / `CPF_CLK_NS)
`define CPF_REARM_CYC ((`CPF_REARM_TIME_NS + `CPF_CLK_NS - 1) / `CPF_CLK_NS)
// Restart hold count; a tripped channel stays off this many cycles plus one before an automatic restart
`define CPF_RESTART_CYC 4
// Number of output channels
`define CPF_NUM_CH 4
// Width of the retry counter and limits
`define CPF_RETRY_W 4
// Width of the on-time and re-arm timers
`define CPF_TIMER_W 16

`endif

// file: rtl/prot_pkg.sv
// Types shared by the channel protection logic
`default_nettype none
package prot_pkg;
  typedef enum logic [1:0] {
    ST_INRUSH,
    ST_OPERATIVE,
    ST_FAULT
  } chan_state_e;
endpackage
`default_nettype wire

// file: rtl/sync2.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: rtl/channel_protection_fsm.sv
// Per-channel protection state machines for a four-channel high-side switch
// How it works
// - Each channel owns an independent state machine
// - Start in inrush: high trip, limited retries
// - Inrush goes operative after on-time limit
// - PWM on-time accumulates toward the limit
// - Any latch-off condition enters fault state
// - Inrush high trip: off, auto restart, limited
// - Retry count survives PWM cycles until latch
// - Overcurrent shutdown sets the error flag
// - Read clears flag unless retries exhausted
// - Cleared flag sets again on next overcurrent
// - Retry limit depends on drain-source voltage
// - Only clear-latch command releases retry latch
// - Clear with demand switches channel on immediately
// - After clear the channel runs operative
// - High drain-source overcurrent in inrush latches without retry
// - That latch also released only by clear
// - Operative uses low trip, latches at once
// - Back to inrush only after long off-time
`timescale 1ns/1ns
`default_nettype none
`include "prot_map.svh"
module channel_protection_fsm #(
  parameter int NCH              = `CPF_NUM_CH,
  parameter int RW               = `CPF_RETRY_W,
  parameter int TW               = `CPF_TIMER_W,
  parameter int INRUSH_ON_CYC    = `CPF_INRUSH_ON_CYC,
  parameter int REARM_CYC        = `CPF_REARM_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic [NCH-1:0]        in_pin,
  input  wire logic [NCH-1:0]        channel_on_bits,
  input  wire logic                  clear_latch_cmd,
  input  wire logic [NCH-1:0]        err_read,
  input  wire logic [NCH-1:0]        over_high_trip,
  input  wire logic [NCH-1:0]        over_low_trip,
  input  wire logic [NCH-1:0]        over_vds_trip,
  input  wire logic [NCH-1:0]        drain_source_threshold,
  input  wire logic [NCH-1:0]        vds_range_high,
  input  wire logic [RW-1:0]         retry_limit_low_vds,
  input  wire logic [RW-1:0]         retry_limit_high_vds,
  output var  logic [NCH-1:0]        switch_on,
  output var  logic [NCH-1:0]        err_flag,
  output var  prot_pkg::chan_state_e chan_state [NCH]
);
  import prot_pkg::*;

  // ******************************************************************
  // Limits
  // ******************************************************************
  // Limits sized to their timers so compares need no extension
  localparam logic [TW-1:0] ON_LIM    = TW'(INRUSH_ON_CYC);
  localparam logic [TW-1:0] REARM_LIM = TW'(REARM_CYC);
  localparam logic [2:0]    RST_HOLD  = 3'(`CPF_RESTART_CYC);

  // ******************************************************************
  // Input synchronisation
  // ******************************************************************
  logic [NCH-1:0] in_s;
  logic [NCH-1:0] hi_s;
  logic [NCH-1:0] lo_s;
  logic [NCH-1:0] vt_s;
  logic [NCH-1:0] dst_s;
  logic [NCH-1:0] rng_s;

  // Stages reset low, so no trip is seen just after reset
  // Pin and comparator levels come from outside the clock domain
  sync2 #(
    .W (6 * NCH)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({in_pin, over_high_trip, over_low_trip, over_vds_trip,
                drain_source_threshold, vds_range_high}),
    .sync_out ({in_s, hi_s, lo_s, vt_s, dst_s, rng_s})
  );

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // True once a timer has reached its limit
  function automatic logic reached(input logic [TW-1:0] cnt,
                                   input logic [TW-1:0] lim);
    reached = (cnt >= lim);
  endfunction

  // Saturating timer step; a stuck timer must not wrap back to zero
  function automatic logic [TW-1:0] tick(input logic [TW-1:0] cnt);
    tick = (cnt == {TW{1'b1}}) ? cnt : cnt + TW'(1);
  endfunction

  // ******************************************************************
  // Channel state
  // ******************************************************************
  chan_state_e    state_d [NCH];
  logic [NCH-1:0] drive_d;
  logic [NCH-1:0] err_d;
  logic [NCH-1:0] sticky_q;
  logic [NCH-1:0] sticky_d;
  logic [RW-1:0]  retry_q [NCH];
  logic [RW-1:0]  retry_d [NCH];
  logic [TW-1:0]  on_q    [NCH];
  logic [TW-1:0]  on_d    [NCH];
  logic [TW-1:0]  rearm_q [NCH];
  logic [TW-1:0]  rearm_d [NCH];
  logic [2:0]     hold_q  [NCH];
  logic [2:0]     hold_d  [NCH];
  logic [NCH-1:0] demand;

  // Either the pin or the SPI on bit asks for the channel
  assign demand = in_s | channel_on_bits;

  // Next-state logic, one independent machine per channel
  always_comb begin
    logic [RW-1:0] lim;
    logic [RW:0]   next_try;
    lim      = '0;
    next_try = '0;
    for (int c = 0; c < NCH; c++) begin
      state_d[c]  = chan_state[c];
      drive_d[c]  = switch_on[c];
      err_d[c]    = err_flag[c];
      sticky_d[c] = sticky_q[c];
      retry_d[c]  = retry_q[c];
      on_d[c]     = on_q[c];
      hold_d[c]   = (hold_q[c] != 3'h0) ? hold_q[c] - 3'h1 : 3'h0;
      // Re-arm timer runs only while the channel is not requested
      rearm_d[c]  = demand[c] ? '0 : tick(rearm_q[c]);
      // Retry budget chosen by the drain-source voltage range
      lim      = rng_s[c] ? retry_limit_high_vds : retry_limit_low_vds;
      next_try = {1'b0, retry_q[c]} + (RW+1)'(1);
      // A read clears the flag, unless retries were exhausted
      if (err_read[c] && !sticky_q[c]) begin
        err_d[c] = 1'b0;
      end
      // Trips count only while driven; an idle channel cannot trip
      case (chan_state[c])
        ST_INRUSH: begin
          if (switch_on[c] && vt_s[c] && dst_s[c]) begin
            // High drain-source overcurrent: latch at once, no retry
            state_d[c] = ST_FAULT;
            drive_d[c] = 1'b0;
            err_d[c]   = 1'b1;
            on_d[c]    = '0;
          end else if (switch_on[c] && hi_s[c]) begin
            err_d[c] = 1'b1;
            on_d[c]  = '0;
            drive_d[c] = 1'b0;
            if (next_try >= {1'b0, lim}) begin
              // Budget spent; flag now survives reads until cleared
              state_d[c]  = ST_FAULT;
              sticky_d[c] = 1'b1;
            end else begin
              retry_d[c] = next_try[RW-1:0];
              hold_d[c]  = RST_HOLD;
            end
          end else if (reached(on_q[c], ON_LIM)) begin
            state_d[c] = ST_OPERATIVE;
            on_d[c]    = '0;
            drive_d[c] = demand[c];
          end else begin
            // On-time accumulates over PWM phases, holds while off
            if (switch_on[c]) begin
              on_d[c] = tick(on_q[c]);
            end
            drive_d[c] = demand[c] && (hold_q[c] == 3'h0);
          end
        end
        ST_OPERATIVE: begin
          on_d[c] = '0;
          if (switch_on[c] && lo_s[c]) begin
            state_d[c] = ST_FAULT;
            drive_d[c] = 1'b0;
            err_d[c]   = 1'b1;
          end else if (!demand[c] && reached(rearm_q[c], REARM_LIM)) begin
            // Long enough off: the inrush budget is restored
            state_d[c] = ST_INRUSH;
            retry_d[c] = '0;
            drive_d[c] = 1'b0;
          end else begin
            drive_d[c] = demand[c];
          end
        end
        ST_FAULT: begin
          on_d[c]    = '0;
          drive_d[c] = 1'b0;
          // Only the clear command releases any latch
          if (clear_latch_cmd) begin
            state_d[c]  = ST_OPERATIVE;
            sticky_d[c] = 1'b0;
            retry_d[c]  = '0;
            // Demand still present restarts the channel at once
            drive_d[c]  = demand[c];
          end
        end
        default: begin
          state_d[c] = ST_FAULT;
          drive_d[c] = 1'b0;
        end
      endcase
    end
  end

  // Registers only; start-up state is inrush with a full budget
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      switch_on <= '0;
      err_flag  <= '0;
      sticky_q  <= '0;
      for (int c = 0; c < NCH; c++) begin
        chan_state[c] <= ST_INRUSH;
        retry_q[c]    <= '0;
        on_q[c]       <= '0;
        rearm_q[c]    <= '0;
        hold_q[c]     <= 3'h0;
      end
    end else begin
      switch_on <= drive_d;
      err_flag  <= err_d;
      sticky_q  <= sticky_d;
      for (int c = 0; c < NCH; c++) begin
        chan_state[c] <= state_d[c];
        retry_q[c]    <= retry_d[c];
        on_q[c]       <= on_d[c];
        rearm_q[c]    <= rearm_d[c];
        hold_q[c]     <= hold_d[c];
      end
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Each check reads only its own channel's machine
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    fault_off_a: assert property (
      chan_state[g] == ST_FAULT |-> !switch_on[g])
      else $error("Channel driven while in fault");
    vds_latch_a: assert property (
      chan_state[g] == ST_INRUSH && switch_on[g] && vt_s[g] && dst_s[g]
      |=> chan_state[g] == ST_FAULT && !switch_on[g] && err_flag[g])
      else $error("High drain-source trip did not latch");
    low_trip_a: assert property (
      chan_state[g] == ST_OPERATIVE && switch_on[g] && lo_s[g]
      |=> chan_state[g] == ST_FAULT && err_flag[g])
      else $error("Operative low trip did not latch");
    retry_rest_a: assert property (
      chan_state[g] == ST_INRUSH && switch_on[g] && hi_s[g]
      && !(vt_s[g] && dst_s[g]) |=> err_flag[g] && !switch_on[g] ##1 !switch_on[g] [*4])
      else $error("Tripped channel restarted too early");
    sticky_err_a: assert property (
      sticky_q[g] && err_read[g] |=> err_flag[g])
      else $error("Exhausted-retry flag cleared by read");
    read_clear_a: assert property (
      !sticky_q[g] && err_read[g] && !switch_on[g] |=> !err_flag[g])
      else $error("Read did not clear error flag");
    clear_op_a: assert property (
      chan_state[g] == ST_FAULT && clear_latch_cmd
      |=> chan_state[g] == ST_OPERATIVE && switch_on[g] == $past(demand[g]))
      else $error("Clear did not restart in operative");
    latch_hold_a: assert property (
      chan_state[g] == ST_FAULT && !clear_latch_cmd |=> chan_state[g] == ST_FAULT)
      else $error("Fault released without clear");
    rearm_a: assert property (
      chan_state[g] == ST_OPERATIVE && !demand[g] && !(switch_on[g] && lo_s[g])
      && rearm_q[g] >= REARM_LIM |=> chan_state[g] == ST_INRUSH)
      else $error("Long off-time did not re-arm inrush");
    inrush_exit_a: assert property (
      chan_state[g] == ST_INRUSH ##1 chan_state[g] == ST_OPERATIVE
      |-> $past(on_q[g]) >= ON_LIM)
      else $error("Left inrush before on-time limit");
    on_hold_a: assert property (
      chan_state[g] == ST_INRUSH && !switch_on[g] && on_q[g] < ON_LIM
      |=> on_q[g] == $past(on_q[g]))
      else $error("On-time changed while channel was off");
    retry_keep_a: assert property (
      chan_state[g] == ST_INRUSH && !(switch_on[g] && hi_s[g])
      |=> retry_q[g] == $past(retry_q[g]))
      else $error("Retry count changed without a trip");
    demand_gate_a: assert property (
      !demand[g] |=> !switch_on[g])
      else $error("Channel driven without its own demand");
    fault_flag_a: assert property (
      chan_state[g] != ST_FAULT ##1 chan_state[g] == ST_FAULT |-> err_flag[g])
      else $error("Fault entered without error flag");

    // Main scenarios worth seeing in a run
    cv_operative: cover property (
      chan_state[g] == ST_INRUSH ##1 chan_state[g] == ST_OPERATIVE);
    cv_retry_fault: cover property (sticky_q[g] && chan_state[g] == ST_FAULT);
    cv_vds_fault: cover property (
      chan_state[g] == ST_INRUSH && switch_on[g] && vt_s[g] && dst_s[g]);
    cv_clear: cover property (
      chan_state[g] == ST_FAULT ##1 chan_state[g] == ST_OPERATIVE && switch_on[g]);
  end
endmodule
`default_nettype wire

// file: sim/host_model.sv
// Host controller model: on bits, flag reads and clear commands
`timescale 1ns/1ns
`default_nettype none
module host_model #(
  parameter int WAIT_CYC = 8
) (
  input  wire logic       clk_sys,
  output var  logic [3:0] channel_on_bits,
  output var  logic [3:0] err_read,
  output var  logic       clear_latch_cmd
);
  // Idle host: nothing demanded, nothing read
  initial begin
    channel_on_bits = 4'h0;
    err_read = 4'h0;
    clear_latch_cmd = 1'b0;
  end
  // Demand changes just after an edge
  task automatic set_on(input logic [3:0] m);
    @(posedge clk_sys) #1 channel_on_bits = m;
  endtask
  // One-cycle read strobe
  task automatic read_flag(input int ch);
    @(posedge clk_sys) #1 err_read[ch] = 1'b1;
    @(posedge clk_sys) #1 err_read = 4'h0;
  endtask
  // Waits out the clear delay first, sparing a hot switch
  task automatic clear_latch();
    repeat (WAIT_CYC) @(posedge clk_sys);
    #1 clear_latch_cmd = 1'b1;
    @(posedge clk_sys) #1 clear_latch_cmd = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the channel protection state machines
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  import prot_pkg::*;
  logic        clk_sys;
  logic        resetn;
  logic [3:0]  in_pin;
  logic [3:0]  channel_on_bits;
  logic        clear_latch_cmd;
  logic [3:0]  err_read;
  logic [3:0]  over_high_trip;
  logic [3:0]  over_low_trip;
  logic [3:0]  over_vds_trip;
  logic [3:0]  drain_source_threshold;
  logic [3:0]  lim_q;
  logic [3:0]  lim_hi_q;
  logic [3:0]  vrng;
  logic [3:0]  switch_on;
  logic [3:0]  err_flag;
  chan_state_e chan_state [4];
  int          fails;
  int          compares;
  int          seed;
  int          k;
  int          lim;
  int          lim_hi;
  int          tries [4];
  chan_state_e exp_st;

  channel_protection_fsm #(.INRUSH_ON_CYC(20), .REARM_CYC(20)) u_channel_protection_fsm (
    .clk_sys(clk_sys), .resetn(resetn), .in_pin(in_pin),
    .channel_on_bits(channel_on_bits), .clear_latch_cmd(clear_latch_cmd),
    .err_read(err_read), .over_high_trip(over_high_trip),
    .over_low_trip(over_low_trip), .over_vds_trip(over_vds_trip),
    .drain_source_threshold(drain_source_threshold), .vds_range_high(vrng),
    .retry_limit_low_vds(lim_q), .retry_limit_high_vds(lim_hi_q),
    .switch_on(switch_on), .err_flag(err_flag), .chan_state(chan_state)
  );
  host_model u_host_model (
    .clk_sys(clk_sys), .channel_on_bits(channel_on_bits),
    .err_read(err_read), .clear_latch_cmd(clear_latch_cmd)
  );

  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic results();
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reference retry model: each trip counts, the limit-th trip latches
  function automatic chan_state_e model_trip(input int ch, input int limit);
    tries[ch] = tries[ch] + 1;
    return (tries[ch] >= limit) ? ST_FAULT : ST_INRUSH;
  endfunction

  // Bounded wait for a state; running out ends the run
  task automatic wait_state(input int ch, input chan_state_e st, input int n);
    int i;
    for (i = 0; i < n && chan_state[ch] !== st; i++) @(posedge clk_sys) #1;
    if (chan_state[ch] !== st) begin
      fails++;
      results();
    end
    `CHK("state", st, chan_state[ch])
  endtask

  // Kind 0 high trip, 1 low trip, 2 high-Vds trip; returns as the answer settles
  task automatic trip(input logic [3:0] m, input int kind);
    @(posedge clk_sys) #1;
    if (kind == 0) over_high_trip = m;
    else if (kind == 1) over_low_trip = m;
    else begin
      over_vds_trip = m;
      drain_source_threshold = m;
    end
    @(posedge clk_sys) #1;
    {over_high_trip, over_low_trip, over_vds_trip, drain_source_threshold} = 16'h0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // Main sequence
  initial begin
    seed = 32'h0b204756;
    lim = 2 + ($unsigned($random(seed)) % 3);
    lim_q = lim[3:0];
    lim_hi = 1 + ($unsigned($random(seed)) % 2);
    lim_hi_q = lim_hi[3:0];
    // Only channel 3 sits in the high drain-source range
    vrng = 4'h8;
    tries = '{0, 0, 0, 0};
    {in_pin, over_high_trip, over_low_trip, over_vds_trip} = 16'h0;
    drain_source_threshold = 4'h0;
    resetn = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 resetn = 1'b1;
    for (k = 0; k < 4; k++) begin
      `CHK("rst_state", ST_INRUSH, chan_state[k])
      `CHK("rst_out", 2'b00, {switch_on[k], err_flag[k]})
    end
    // Steady on-time versus split on-time
    u_host_model.set_on(4'h1);
    wait_state(0, ST_OPERATIVE, 40);
    `CHK("idle_ch", ST_INRUSH, chan_state[1])
    u_host_model.set_on(4'h3);
    repeat (12) @(posedge clk_sys);
    u_host_model.set_on(4'h1);
    repeat (5) @(posedge clk_sys) #1;
    `CHK("pwm_mid", ST_INRUSH, chan_state[1])
    u_host_model.set_on(4'h3);
    wait_state(1, ST_OPERATIVE, 15);
    // Retries through modulation cycles until latch
    u_host_model.set_on(4'h7);
    for (k = 1; k <= lim; k++) begin
      trip(4'h4, 0);
      exp_st = model_trip(2, lim);
      `CHK("off", 1'b0, switch_on[2])
      `CHK("err", 1'b1, err_flag[2])
      `CHK("rtry", exp_st, chan_state[2])
      u_host_model.read_flag(2);
      `CHK("err_rd", exp_st == ST_FAULT, err_flag[2])
      u_host_model.set_on(4'h3);
      repeat (3) @(posedge clk_sys);
      u_host_model.set_on(4'h7);
      repeat (3) @(posedge clk_sys) #1;
      `CHK("restart", exp_st != ST_FAULT, switch_on[2])
    end
    // Low trip in operative latches at once
    trip(4'h1, 1);
    `CHK("low_trip", ST_FAULT, chan_state[0])
    `CHK("low_off", 1'b0, switch_on[0])
    // High-Vds range allows one or two tries (lim_hi); demand from the pin
    @(posedge clk_sys) #1 in_pin = 4'h8;
    repeat (4) @(posedge clk_sys);
    for (k = 1; k <= lim_hi; k++) begin
      trip(4'h8, 0);
      exp_st = model_trip(3, lim_hi);
      `CHK("hv_rtry", exp_st, chan_state[3])
    end
    `CHK("other_ch", 2'b11, {chan_state[1] == ST_OPERATIVE, switch_on[1]})
    u_host_model.clear_latch();
    // Clear empties the retry count of every latched channel
    tries = '{0, 0, 0, 0};
    @(posedge clk_sys) #1;
    for (k = 0; k < 4; k++) begin
      if (k == 1) continue;
      `CHK("clr_state", ST_OPERATIVE, chan_state[k])
      `CHK("clr_on", 1'b1, switch_on[k])
    end
    // Off long enough re-arms inrush, never sooner
    u_host_model.set_on(4'h3);
    repeat (10) @(posedge clk_sys) #1;
    `CHK("rearm_early", ST_OPERATIVE, chan_state[2])
    wait_state(2, ST_INRUSH, 30);
    u_host_model.set_on(4'h7);
    repeat (2) @(posedge clk_sys);
    trip(4'h4, 2);
    `CHK("vds_trip", ST_FAULT, chan_state[2])
    repeat (6) @(posedge clk_sys) #1;
    `CHK("vds_noretry", 2'b01, {switch_on[2], err_flag[2]})
    u_host_model.clear_latch();
    @(posedge clk_sys) #1;
    `CHK("vds_clr", 2'b11, {chan_state[2] == ST_OPERATIVE, switch_on[2]})
    results();
  end
endmodule
`default_nettype wire
